//--- test_tape_formatter_motion_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_tape_formatter_motion_sequencer;
   logic ref_clk_in = 1'b0, reset_n_in = 1'b0, cmd_load_in = 1'b0, frame_count_load_in = 1'b0, run_in = 1'b0;
   logic attention_line_clear_in = 1'b0, unit_present_in = 1'b1, word_ready_in = 1'b1, bot_in = 1'b0, eot_in = 1'b0;
   logic tape_mark_in = 1'b0, char_strobe_in = 1'b0, identification_burst_in = 1'b0, postamble_in = 1'b0;
   logic unit_status_change_in, record_gap_in, exec_busy_out, cmd_error_out, data_bus_occupied_out;
   logic end_of_block_out, attention_line_out, word_valid_out, data_late_out, rewind_line_out, write_line_out;
   logic forward_line_out, reverse_line_out, set_pulse_out, stop_out, motion_delay_enable_out;
   logic [5:0] func_code_in = 6'h00;
   logic [2:0] unit_sel_in = 3'h2, unit_select_out;
   logic [15:0] frame_count_in = 16'h0000, frame_count_out;
   logic [7:0] read_data_in, char_q = 8'h00;
   logic [7:0] chars[5] = '{8'h05, 8'hff, 8'h01, 8'h02, 8'h03};
   logic [17:0] word_data_out, last_word;
   int failures = 0, checks_done = 0, cyc = 0, words = 0, blocks = 0, n, sets, stops, last;
   always #12.5 ref_clk_in = ~ref_clk_in;
   tfm_sequencer u_dut (.ref_clk_in, .reset_n_in, .cmd_load_in, .func_code_in, .unit_sel_in, .frame_count_load_in,
      .frame_count_in, .run_in, .attention_line_clear_in, .unit_present_in, .word_ready_in, .exec_busy_out, .cmd_error_out,
      .data_bus_occupied_out, .end_of_block_out, .attention_line_out, .frame_count_out, .word_valid_out,
      .word_data_out, .data_late_out, .unit_status_change_in, .record_gap_in, .bot_in, .eot_in, .tape_mark_in,
      .char_strobe_in, .identification_burst_in, .postamble_in, .read_data_in, .unit_select_out,
      .rewind_line_out, .write_line_out, .forward_line_out, .reverse_line_out, .set_pulse_out, .stop_out,
      .motion_delay_enable_out);
   tfm_tape_model u_tape (.ref_clk_in, .set_in(set_pulse_out), .stop_in(stop_out),
      .enable_in(motion_delay_enable_out), .rewind_in(rewind_line_out), .write_in(write_line_out),
      .char_in(char_q), .status_change_out(unit_status_change_in), .gap_out(record_gap_in),
      .read_data_out(read_data_in));
   always @(posedge ref_clk_in) begin
      if (word_valid_out && word_ready_in) last_word <= word_data_out;
      words <= words + int'(word_valid_out && word_ready_in);
      blocks <= blocks + int'(end_of_block_out === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict;
      end
   end
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // All driving and sampling sits 2 ns after the edge, clear of flop updates
   task automatic step;
      @(posedge ref_clk_in);
      #2;
   endtask : step
   task automatic issue(input logic [5:0] code);
      func_code_in = code;
      cmd_load_in = 1'b1;
      step;
      cmd_load_in = 1'b0;
      for (n = 0; n < 100 && set_pulse_out !== 1'b1; n++) step;
   endtask : issue
   task automatic finish_op;
      sets = 1;
      stops = 0;
      last = 0;
      for (n = 1; n < 3000 && exec_busy_out === 1'b1; n++) begin
         step;
         if (stop_out === 1'b1) stops++;
         if (stop_out === 1'b1) last = n;
         if (set_pulse_out === 1'b1) sets++;
         if (set_pulse_out === 1'b1) chk(n - last <= 40, 1);
      end
   endtask : finish_op
   task automatic rewind_op(input logic [5:0] code, input logic wr);
      issue(code);
      chk({rewind_line_out, write_line_out, stop_out, unit_select_out}, {1'b1, wr, 1'b1, 3'h2});
      step;
      chk(exec_busy_out, 0);
      for (n = 0; n < 80 && attention_line_out !== 1'b1; n++) step;
      chk(attention_line_out, 1);
      attention_line_clear_in = 1'b1;
      step;
      attention_line_clear_in = 1'b0;
      step;
      chk(attention_line_out, 0);
   endtask : rewind_op
   task automatic space_op(input logic [5:0] code, input logic [15:0] cnt, input logic fwd, input int exp_sets);
      int w0;
      w0 = words;
      frame_count_in = cnt;
      frame_count_load_in = 1'b1;
      step;
      frame_count_load_in = 1'b0;
      issue(code);
      chk({forward_line_out, reverse_line_out, motion_delay_enable_out}, {fwd, !fwd, 1'b1});
      finish_op;
      chk(sets, exp_sets);
      chk(frame_count_out, 0);
      chk(words - w0, 0);
   endtask : space_op
   task automatic read_op(input logic [5:0] code);
      int w0, b0;
      w0 = words;
      b0 = blocks;
      run_in = 1'b1;
      issue(code);
      chk({data_bus_occupied_out, forward_line_out, reverse_line_out}, {1'b1, !code[1], code[1]});
      repeat (8) step;
      identification_burst_in = 1'b1;
      // Strobe held two cycles so the synchroniser cannot miss it
      foreach (chars[i]) begin
         char_q = chars[i];
         step;
         char_strobe_in = 1'b1;
         repeat (2) step;
         char_strobe_in = 1'b0;
         repeat (2) step;
      end
      postamble_in = 1'b1;
      repeat (3) step;
      postamble_in = 1'b0;
      finish_op;
      identification_burst_in = 1'b0;
      run_in = 1'b0;
      chk(words - w0, 1);
      chk(last_word, 18'h01083);
      chk({31'(blocks - b0), data_bus_occupied_out}, {31'h1, 1'b0});
   endtask : read_op
   initial begin
      repeat (6) step;
      reset_n_in = 1'b1;
      step;
      rewind_op(tfm_pkg::FC_REWIND, 1'b0);
      rewind_op(tfm_pkg::FC_REWIND_OFFLINE, 1'b1);
      space_op(tfm_pkg::FC_SPACE_FWD, 16'hfffe, 1'b1, 2);
      space_op(tfm_pkg::FC_SPACE_REV, 16'hffff, 1'b0, 1);
      func_code_in = tfm_pkg::FC_SPACE_FWD;
      cmd_load_in = 1'b1;
      step;
      cmd_load_in = 1'b0;
      step;
      chk({cmd_error_out, exec_busy_out, data_late_out}, 3'h4);
      issue(tfm_pkg::FC_ERASE);
      chk({forward_line_out, write_line_out, motion_delay_enable_out}, 3'h7);
      finish_op;
      chk({stops[30:0], exec_busy_out}, {31'h1, 1'b0});
      read_op(tfm_pkg::FC_READ_FWD);
      read_op(tfm_pkg::FC_READ_REV);
      read_op(tfm_pkg::FC_CHECK_FWD);
      read_op(tfm_pkg::FC_CHECK_REV);
      print_verdict;
   end
endmodule : test_tape_formatter_motion_sequencer
`default_nettype wire

//--- tfm_motion_delay.sv
`timescale 1ns/10ps
`default_nettype none
module tfm_motion_delay #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Preset load and completion
   input wire logic load_in,
   input wire logic [W-1:0] preset_in,
   output logic done_out
);
   localparam logic [W-1:0] DONE_COUNT = W'(tfm_pkg::UP_TO_SPEED_COUNT);
   logic [W-1:0] count_q;
   logic busy_q;
   wire logic at_end = busy_q && (count_q == DONE_COUNT);

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_q <= '0;
         busy_q <= 1'b0;
         done_out <= 1'b0;
      end else if (load_in) begin
         count_q <= preset_in;
         busy_q <= 1'b1;
         done_out <= 1'b0;
      end else begin
         done_out <= at_end;
         busy_q <= busy_q && !at_end;
         if (busy_q && !at_end) begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   property p_delay_end;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      at_end && !load_in |=> done_out && !busy_q;
   endproperty
   a_delay_end: assert property (p_delay_end) else $error("delay did not end at count two");
endmodule : tfm_motion_delay
`default_nettype wire

//--- tfm_pkg.sv
`default_nettype none
package tfm_pkg;
   // Function codes with the execute bit in bit 0
   localparam logic [5:0] FC_REWIND_OFFLINE = 6'h03;
   localparam logic [5:0] FC_REWIND = 6'h07;
   localparam logic [5:0] FC_ERASE = 6'h15;
   localparam logic [5:0] FC_SPACE_FWD = 6'h19;
   localparam logic [5:0] FC_SPACE_REV = 6'h1b;
   localparam logic [5:0] FC_CHECK_FWD = 6'h29;
   localparam logic [5:0] FC_CHECK_REV = 6'h2f;
   localparam logic [5:0] FC_READ_FWD = 6'h39;
   localparam logic [5:0] FC_READ_REV = 6'h3f;

   localparam int CLK_PERIOD_NS = 25;
   localparam int RESTART_GAP_NS = 1000;
   localparam int RESTART_CYCLES = (RESTART_GAP_NS / CLK_PERIOD_NS < 4) ? 4 : RESTART_GAP_NS / CLK_PERIOD_NS;
   // Stop, gap exit and set states take three of the cycles
   localparam logic [5:0] RESTART_WAIT = 6'(RESTART_CYCLES - 3);
   localparam logic [1:0] PRESET_SETTLE = 2'h3;
   localparam int UP_TO_SPEED_COUNT = 2;
   localparam logic [7:0] PREAMBLE_MARK = 8'hff;

   localparam int WORD_W = 18;
   localparam int CHAR_W = 6;
   localparam int CHARS_PER_WORD = 3;

   // Positions in the synchronised pin vector
   localparam int SY_USC = 0;
   localparam int SY_GAP = 1;
   localparam int SY_BOT = 2;
   localparam int SY_EOT = 3;
   localparam int SY_TMK = 4;
   localparam int SY_STB = 5;
   localparam int SY_IDB = 6;
   localparam int SY_PST = 7;
   localparam int SY_CTRL_W = 8;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_CHECK = 3'h1, S_SET = 3'h2, S_LOAD = 3'h3,
      S_DELAY = 3'h4, S_MOVE = 3'h5, S_STOP = 3'h6, S_GAP = 3'h7
   } tfm_state_t;
   typedef enum logic [1:0] {OP_REWIND = 2'h0, OP_SPACE = 2'h1, OP_ERASE = 2'h2, OP_READ = 2'h3} tfm_op_t;
   typedef enum logic [1:0] {AF_MOVE = 2'h0, AF_SECOND = 2'h1, AF_STOP = 2'h2} tfm_after_t;
   typedef enum logic [1:0] {RD_IDB = 2'h0, RD_PRE = 2'h1, RD_DATA = 2'h2, RD_OFF = 2'h3} tfm_rd_phase_t;
endpackage : tfm_pkg
`default_nettype wire

//--- tfm_sequencer.sv
// Operation
// - Rewind code raises rewind line; offline rewind also raises write line
// - Rewind passing checks: set pulse with stop, execute bit cleared at once
// - Unit status change sets attention and drives attention line
// - Code 31 space forward, 33 space reverse, matching motion line
// - Host preloads negative record count; set pulse and delay enable follow
// - Transport drives presets on read data; they time motion delays
// - Spacing ignores characters and assembles no words
// - Each gap: count up, delay, stop, new set pulse within a microsecond
// - Space ends on count overflow, tape start, end or mark
// - Code 25 erase: forward and write lines, then set and delay enable
// - Erase delay counts up from preset, up to speed at two
// - Erase start delay, then stop delay, then stop and clear execute
// - Read and write check codes drive forward or reverse on acceptance, before run
// - Read: occupied first, then set pulse and motion delay
// - Read hunts burst and preamble during acceleration; data follows all-ones
// - Characters pack into 18-bit words handed to the host
// - Postamble: end of block, delay, stop, clear execute and occupied
// - Octal 07 rewind stays online, 03 rewind goes offline
`timescale 1ns/10ps
`default_nettype none
module tfm_sequencer #(
   parameter int FC_W = 16
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Host command side
   input wire logic cmd_load_in,
   input wire logic [5:0] func_code_in,
   input wire logic [2:0] unit_sel_in,
   input wire logic frame_count_load_in,
   input wire logic [FC_W-1:0] frame_count_in,
   input wire logic run_in,
   input wire logic attention_line_clear_in,
   input wire logic unit_present_in,
   input wire logic word_ready_in,
   // Host status and data
   output logic exec_busy_out,
   output logic cmd_error_out,
   output logic data_bus_occupied_out,
   output logic end_of_block_out,
   output logic attention_line_out,
   output logic [FC_W-1:0] frame_count_out,
   output logic word_valid_out,
   output logic [tfm_pkg::WORD_W-1:0] word_data_out,
   output logic data_late_out,
   // Transport pins in
   input wire logic unit_status_change_in,
   input wire logic record_gap_in,
   input wire logic bot_in,
   input wire logic eot_in,
   input wire logic tape_mark_in,
   input wire logic char_strobe_in,
   input wire logic identification_burst_in,
   input wire logic postamble_in,
   input wire logic [7:0] read_data_in,
   // Transport lines out
   output logic [2:0] unit_select_out,
   output logic rewind_line_out,
   output logic write_line_out,
   output logic forward_line_out,
   output logic reverse_line_out,
   output logic set_pulse_out,
   output logic stop_out,
   output logic motion_delay_enable_out
);
   localparam int SYW = tfm_pkg::SY_CTRL_W + 8;
   localparam int WW = tfm_pkg::WORD_W;
   localparam int CW = tfm_pkg::CHAR_W;
   localparam logic [1:0] LAST_CHAR = 2'(tfm_pkg::CHARS_PER_WORD - 1);

   wire logic [SYW-1:0] pins_raw = {read_data_in, postamble_in, identification_burst_in, char_strobe_in,
      tape_mark_in, eot_in, bot_in, record_gap_in, unit_status_change_in};
   logic [SYW-1:0] sy_lvl;
   logic [SYW-1:0] sy_rise;

   // Read data pass the same two stages; they are stable long before the strobe edge arrives
   generate
      for (genvar g = 0; g < SYW; g++) begin : g_sync
         logic s1_q, s2_q, s3_q;
         always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= pins_raw[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         assign sy_lvl[g] = s2_q;
         assign sy_rise[g] = s2_q && !s3_q;
      end
   endgenerate

   wire logic usc_rise = sy_rise[tfm_pkg::SY_USC];
   wire logic gap_rise = sy_rise[tfm_pkg::SY_GAP];
   wire logic stb_rise = sy_rise[tfm_pkg::SY_STB];
   wire logic pst_rise = sy_rise[tfm_pkg::SY_PST];
   wire logic idb_lvl = sy_lvl[tfm_pkg::SY_IDB];
   wire logic tape_end_lvl = sy_lvl[tfm_pkg::SY_BOT] || sy_lvl[tfm_pkg::SY_EOT] || sy_lvl[tfm_pkg::SY_TMK];
   wire logic [7:0] rd_char = sy_lvl[SYW-1 -: 8];

   tfm_pkg::tfm_state_t state_q;
   tfm_pkg::tfm_op_t op_q;
   tfm_pkg::tfm_after_t after_q;
   tfm_pkg::tfm_rd_phase_t rd_phase_q;
   logic [1:0] settle_q;
   logic [5:0] gap_q;
   logic term_q;
   logic fcs_q;
   logic [WW-1:0] asm_q;
   logic [1:0] nchar_q;
   logic dly_done;

   // Command decode
   wire logic cmd_ok = cmd_load_in && !exec_busy_out && func_code_in[0];
   wire logic is_rew_off = func_code_in == tfm_pkg::FC_REWIND_OFFLINE;
   wire logic is_rew = is_rew_off || func_code_in == tfm_pkg::FC_REWIND;
   wire logic is_sp_fwd = func_code_in == tfm_pkg::FC_SPACE_FWD;
   wire logic is_sp_rev = func_code_in == tfm_pkg::FC_SPACE_REV;
   wire logic is_erase = func_code_in == tfm_pkg::FC_ERASE;
   wire logic is_rd_fwd = func_code_in == tfm_pkg::FC_READ_FWD || func_code_in == tfm_pkg::FC_CHECK_FWD;
   wire logic is_rd_rev = func_code_in == tfm_pkg::FC_READ_REV || func_code_in == tfm_pkg::FC_CHECK_REV;
   wire logic known = is_rew || is_sp_fwd || is_sp_rev || is_erase || is_rd_fwd || is_rd_rev;
   wire logic check_fail = !unit_present_in || (op_q == tfm_pkg::OP_SPACE && !fcs_q);
   wire logic dly_load = state_q == tfm_pkg::S_LOAD && settle_q == tfm_pkg::PRESET_SETTLE;
   wire logic [FC_W-1:0] fc_next = frame_count_out + 1'b1;
   wire logic space_done = op_q != tfm_pkg::OP_SPACE || term_q || frame_count_out == '0;
   wire logic read_on = exec_busy_out && op_q == tfm_pkg::OP_READ;

   tfm_word_if #(.W(WW)) push ();
   assign push.data = asm_q;

   tfm_motion_delay #(.W(8)) u_delay (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(dly_load),
      .preset_in(rd_char),
      .done_out(dly_done)
   );

   tfm_word_buffer #(.W(WW)) u_buffer (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .push(push),
      .out_valid_out(word_valid_out),
      .out_data_out(word_data_out),
      .out_ready_in(word_ready_in)
   );

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= tfm_pkg::S_IDLE;
         op_q <= tfm_pkg::OP_REWIND;
         after_q <= tfm_pkg::AF_MOVE;
         exec_busy_out <= 1'b0;
         data_bus_occupied_out <= 1'b0;
         cmd_error_out <= 1'b0;
         unit_select_out <= 3'h0;
         {rewind_line_out, write_line_out, forward_line_out, reverse_line_out} <= 4'h0;
         {set_pulse_out, stop_out, motion_delay_enable_out} <= 3'h0;
         frame_count_out <= '0;
         fcs_q <= 1'b0;
         settle_q <= 2'h0;
         gap_q <= 6'h0;
         term_q <= 1'b0;
      end else begin
         set_pulse_out <= 1'b0;
         stop_out <= 1'b0;
         cmd_error_out <= 1'b0;
         unique case (state_q)
            tfm_pkg::S_IDLE: begin
               {rewind_line_out, write_line_out, forward_line_out, reverse_line_out} <= 4'h0;
               if (frame_count_load_in) begin
                  frame_count_out <= frame_count_in;
                  fcs_q <= 1'b1;
               end
               if (cmd_ok && known) begin
                  exec_busy_out <= 1'b1;
                  unit_select_out <= unit_sel_in;
                  term_q <= 1'b0;
                  rewind_line_out <= is_rew;
                  write_line_out <= is_rew_off || is_erase;
                  forward_line_out <= is_sp_fwd || is_erase || is_rd_fwd;
                  reverse_line_out <= is_sp_rev || is_rd_rev;
                  op_q <= is_rew ? tfm_pkg::OP_REWIND : (is_erase ? tfm_pkg::OP_ERASE :
                     ((is_sp_fwd || is_sp_rev) ? tfm_pkg::OP_SPACE : tfm_pkg::OP_READ));
                  after_q <= is_erase ? tfm_pkg::AF_SECOND : tfm_pkg::AF_MOVE;
                  state_q <= tfm_pkg::S_CHECK;
               end
            end
            tfm_pkg::S_CHECK: begin
               if (check_fail) begin
                  cmd_error_out <= 1'b1;
                  exec_busy_out <= 1'b0;
                  state_q <= tfm_pkg::S_IDLE;
               end else if (op_q == tfm_pkg::OP_REWIND) begin
                  set_pulse_out <= 1'b1;
                  stop_out <= 1'b1;
                  exec_busy_out <= 1'b0;
                  state_q <= tfm_pkg::S_IDLE;
               end else if (op_q != tfm_pkg::OP_READ) begin
                  state_q <= tfm_pkg::S_SET;
               end else if (run_in) begin
                  data_bus_occupied_out <= 1'b1;
                  state_q <= tfm_pkg::S_SET;
               end
            end
            tfm_pkg::S_SET: begin
               set_pulse_out <= 1'b1;
               motion_delay_enable_out <= 1'b1;
               settle_q <= 2'h0;
               state_q <= tfm_pkg::S_LOAD;
            end
            tfm_pkg::S_LOAD: begin
               // The preset must cross the pin synchroniser before it is loaded
               settle_q <= settle_q + 2'h1;
               if (dly_load) begin
                  motion_delay_enable_out <= 1'b0;
                  state_q <= tfm_pkg::S_DELAY;
               end
            end
            tfm_pkg::S_DELAY: begin
               if (dly_done) begin
                  unique case (after_q)
                     tfm_pkg::AF_MOVE: state_q <= tfm_pkg::S_MOVE;
                     tfm_pkg::AF_SECOND: begin
                        after_q <= tfm_pkg::AF_STOP;
                        motion_delay_enable_out <= 1'b1;
                        settle_q <= 2'h0;
                        state_q <= tfm_pkg::S_LOAD;
                     end
                     tfm_pkg::AF_STOP: begin
                        stop_out <= 1'b1;
                        state_q <= tfm_pkg::S_STOP;
                     end
                     default: state_q <= tfm_pkg::S_STOP;
                  endcase
               end
            end
            tfm_pkg::S_MOVE: begin
               if (op_q == tfm_pkg::OP_SPACE && tape_end_lvl) begin
                  stop_out <= 1'b1;
                  term_q <= 1'b1;
                  state_q <= tfm_pkg::S_STOP;
               end else if ((op_q == tfm_pkg::OP_SPACE && gap_rise) || rd_phase_q == tfm_pkg::RD_OFF) begin
                  if (op_q == tfm_pkg::OP_SPACE) begin
                     frame_count_out <= fc_next;
                     fcs_q <= fc_next != '0;
                  end
                  after_q <= tfm_pkg::AF_STOP;
                  motion_delay_enable_out <= 1'b1;
                  settle_q <= 2'h0;
                  state_q <= tfm_pkg::S_LOAD;
               end
            end
            tfm_pkg::S_STOP: begin
               if (space_done) begin
                  exec_busy_out <= 1'b0;
                  data_bus_occupied_out <= 1'b0;
                  state_q <= tfm_pkg::S_IDLE;
               end else begin
                  after_q <= tfm_pkg::AF_MOVE;
                  gap_q <= 6'h0;
                  state_q <= tfm_pkg::S_GAP;
               end
            end
            tfm_pkg::S_GAP: begin
               // Short gap keeps the capstan from visibly slowing between records
               gap_q <= gap_q + 6'h1;
               if (gap_q == tfm_pkg::RESTART_WAIT) begin
                  state_q <= tfm_pkg::S_SET;
               end
            end
         endcase
      end
   end

   // Read character path; idle for every other command, so spacing delivers nothing
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_phase_q <= tfm_pkg::RD_IDB;
         asm_q <= '0;
         nchar_q <= 2'h0;
         push.valid <= 1'b0;
         end_of_block_out <= 1'b0;
         data_late_out <= 1'b0;
      end else if (!read_on) begin
         rd_phase_q <= tfm_pkg::RD_IDB;
         nchar_q <= 2'h0;
         push.valid <= 1'b0;
         end_of_block_out <= 1'b0;
         data_late_out <= data_late_out && !cmd_ok;
      end else begin
         push.valid <= 1'b0;
         end_of_block_out <= 1'b0;
         unique case (rd_phase_q)
            tfm_pkg::RD_IDB: if (idb_lvl) rd_phase_q <= tfm_pkg::RD_PRE;
            tfm_pkg::RD_PRE: if (stb_rise && rd_char == tfm_pkg::PREAMBLE_MARK) rd_phase_q <= tfm_pkg::RD_DATA;
            tfm_pkg::RD_DATA: begin
               if (pst_rise) begin
                  end_of_block_out <= 1'b1;
                  rd_phase_q <= tfm_pkg::RD_OFF;
               end else if (stb_rise) begin
                  asm_q <= {asm_q[WW-CW-1:0], rd_char[CW-1:0]};
                  nchar_q <= (nchar_q == LAST_CHAR) ? 2'h0 : nchar_q + 2'h1;
                  if (nchar_q == LAST_CHAR) begin
                     push.valid <= push.ready;
                     data_late_out <= data_late_out || !push.ready;
                  end
               end
            end
            tfm_pkg::RD_OFF: rd_phase_q <= tfm_pkg::RD_OFF;
         endcase
      end
   end

   // A status change in the same cycle as a clear keeps the flag set
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         attention_line_out <= 1'b0;
      end else if (usc_rise) begin
         attention_line_out <= 1'b1;
      end else if (attention_line_clear_in) begin
         attention_line_out <= 1'b0;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   property p_rewind_lines;
      cmd_ok && is_rew_off |=> rewind_line_out && write_line_out;
   endproperty
   a_rewind_lines: assert property (p_rewind_lines) else $error("offline rewind lines missing");
   property p_rewind_free;
      $rose(rewind_line_out) && unit_present_in |=> set_pulse_out && stop_out && !exec_busy_out;
   endproperty
   a_rewind_free: assert property (p_rewind_free) else $error("rewind did not release");
   property p_attention;
      usc_rise |=> attention_line_out;
   endproperty
   a_attention: assert property (p_attention) else $error("attention not set");
   property p_space_rev;
      cmd_ok && is_sp_rev |=> reverse_line_out && !forward_line_out;
   endproperty
   a_space_rev: assert property (p_space_rev) else $error("space reverse line wrong");
   property p_gap_count;
      state_q == tfm_pkg::S_MOVE && op_q == tfm_pkg::OP_SPACE && gap_rise && !tape_end_lvl
         |=> frame_count_out == FC_W'($past(frame_count_out) + 1'b1);
   endproperty
   a_gap_count: assert property (p_gap_count) else $error("frame count not advanced");
   property p_overflow_end;
      state_q == tfm_pkg::S_STOP && op_q == tfm_pkg::OP_SPACE && frame_count_out == '0
         |=> !exec_busy_out ##1 !set_pulse_out;
   endproperty
   a_overflow_end: assert property (p_overflow_end) else $error("space ran past overflow");
   property p_erase_lines;
      cmd_ok && is_erase |=> forward_line_out && write_line_out;
   endproperty
   a_erase_lines: assert property (p_erase_lines) else $error("erase lines missing");
   property p_erase_end;
      stop_out && op_q == tfm_pkg::OP_ERASE |=> !exec_busy_out;
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("erase kept execute");
   property p_no_space_words;
      op_q == tfm_pkg::OP_SPACE |-> !push.valid;
   endproperty
   a_no_space_words: assert property (p_no_space_words) else $error("word during space");
   property p_occ_then_set;
      $rose(data_bus_occupied_out) |=> set_pulse_out && motion_delay_enable_out;
   endproperty
   a_occ_then_set: assert property (p_occ_then_set) else $error("set did not follow occupied");
   property p_read_end;
      stop_out && op_q == tfm_pkg::OP_READ |=> !data_bus_occupied_out && !exec_busy_out;
   endproperty
   a_read_end: assert property (p_read_end) else $error("read end left occupied");

   c_rewind: cover property (set_pulse_out && rewind_line_out);
   c_space_restart: cover property (state_q == tfm_pkg::S_GAP ##[1:60] set_pulse_out);
   c_word: cover property (push.valid && push.ready);
   c_erase_done: cover property (stop_out && op_q == tfm_pkg::OP_ERASE);
endmodule : tfm_sequencer
`default_nettype wire

//--- tfm_tape_model.sv
`timescale 1ns/10ps
`default_nettype none
module tfm_tape_model #(parameter logic [7:0] PRESET = 8'h00, parameter int GAP = 50) (
   // Lines from the sequencer
   input wire logic ref_clk_in,
   input wire logic set_in, stop_in, enable_in, rewind_in, write_in,
   input wire logic [7:0] char_in,
   // Lines back to the sequencer
   output logic status_change_out,
   output logic gap_out,
   output logic [7:0] read_data_out
);
   logic moving_q = 1'b0;
   int rew_q = 0;
   int run_q = 0;
   // Presets only while delay enable stands, else the tape character
   assign read_data_out = enable_in ? PRESET : char_in;
   // A record gap shows every GAP+1 cycles of motion
   assign gap_out = moving_q && run_q > GAP - 4;
   always @(posedge ref_clk_in) begin
      status_change_out <= rew_q == 1;
      rew_q <= (set_in && rewind_in) ? 30 : (rew_q > 0 ? rew_q - 1 : 0);
      if (set_in && !rewind_in) moving_q <= 1'b1;
      else if (stop_in) moving_q <= 1'b0;
      run_q <= (moving_q && run_q < GAP) ? run_q + 1 : 0;
   end
endmodule : tfm_tape_model
`default_nettype wire

//--- tfm_word_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module tfm_word_buffer #(
   parameter int W = 18
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Filling side
   tfm_word_if.snk push,
   // Draining side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   logic [W-1:0] d1_q;
   logic v1_q;
   wire logic pop = out_valid_out && out_ready_in;
   wire logic take = push.valid && !v1_q;

   // Head entry sits in the output register so the host sees a flop
   assign push.ready = !v1_q;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_valid_out <= 1'b0;
         out_data_out <= '0;
         d1_q <= '0;
         v1_q <= 1'b0;
      end else if (pop) begin
         out_valid_out <= v1_q || take;
         out_data_out <= v1_q ? d1_q : push.data;
         v1_q <= v1_q && take;
         if (v1_q && take) begin
            d1_q <= push.data;
         end
      end else if (take) begin
         if (!out_valid_out) begin
            out_valid_out <= 1'b1;
            out_data_out <= push.data;
         end else begin
            v1_q <= 1'b1;
            d1_q <= push.data;
         end
      end
   end
endmodule : tfm_word_buffer
`default_nettype wire

//--- tfm_word_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tfm_word_if #(parameter int W = 18);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : tfm_word_if
`default_nettype wire
